// ===== rtl/dvp_device.sv
// device end: verify-sectors and password-disable command interpreter
//
// Contract
// - no packet set: verify supported; else refused
// - opcode 40h verifies, never raises data request
// - sector count zero means 256 sectors
// - address assembled from four task-file fields
// - head bit 6 selects block or CHS addressing
// - success: not busy, ready, no fault/request/error
// - failing sector address left in address registers
// - uncorrectable data sets error bit 6
// - media changed reported once, then forgotten
// - unfound address or no geometry sets bit 4
// - media change request reported, cleared by access
// - unsupported command sets abort bit 2
// - out of range flagged by address-not-found only
// - missing medium sets no-media bit 1
// - error: ready, fault only on fault, error set
// - abort also when device cannot complete
// - opcode F6h takes one data-out sector
// - abort disable when unsupported, locked or frozen
// - host issues disable only when ready, unlocked; adapter refuses only on not ready or busy
// - word 0 bit 0 picks password, words 1-16
// - match leaves lock mode, master kept
`timescale 1ns/10ps
`default_nettype none
`include "dvp_regs.svh"
module dvp_device (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // task-file link
  dvp_if.device            tf,
  // device configuration
  input  wire logic        packet_set,
  input  wire logic        removable,
  input  wire logic        sec_supported,
  input  wire logic        sec_locked,
  input  wire logic        sec_frozen,
  input  wire logic        chs_valid,
  input  wire logic        dev_fault,
  input  wire logic [27:0] max_lba,
  input  wire logic [7:0]  geom_spt,
  input  wire logic [4:0]  geom_heads,
  // media events
  input  wire logic        media_change_evt,
  input  wire logic        media_change_req_evt,
  input  wire logic        no_media,
  // media verify handshake
  output logic             media_req,
  output logic [27:0]      media_addr,
  output logic             media_lba,
  input  wire logic        media_ack,
  input  wire logic        media_unc,
  input  wire logic        media_nf,
  // password store
  input  wire logic        pw_load,
  input  wire logic        pw_master,
  input  wire logic [3:0]  pw_idx,
  input  wire logic [15:0] pw_word,
  output logic             lock_mode
);
  dvp_pkg::dvp_dev_state_t state_q, state_d;
  logic [7:0]  op_q, cnt_q, sect_q, cyllo_q, cylhi_q, head_q, status_q, error_q;
  logic [8:0]  remain_q, widx_q;
  logic        first_q, sel_master_q, mc_pend_q, mcr_pend_q;
  logic        fin;
  logic [7:0]  fin_err;
  logic [15:0] pw_usr [16];
  logic [15:0] pw_mst [16];
  logic        pw_match;

  // ********************************************************
  // decode
  // ********************************************************
  wire idle    = state_q == dvp_pkg::S_IDLE;
  wire tf_ld   = tf.tf_wr && idle;
  wire cmd_wr  = tf_ld && (tf.tf_addr == `DVP_TF_CMD);
  wire is_vfy  = op_q == `DVP_OP_VERIFY;
  wire is_pw   = op_q == `DVP_OP_PWDIS;
  wire in_chk  = state_q == dvp_pkg::S_CHECK;
  wire in_wait = state_q == dvp_pkg::S_WAIT;
  wire pw_take = (state_q == dvp_pkg::S_DATA) && tf.pio_wr;

  // address assembly and range check
  wire        lba_mode  = head_q[`DVP_HD_LBA];
  wire [27:0] lba_cur   = {head_q[3:0], cylhi_q, cyllo_q, sect_q};
  wire [27:0] lba_nx    = lba_cur + 28'h0000001;
  wire        chs_bad   = (sect_q == 8'h00) || (sect_q > geom_spt) || ({1'b0, head_q[3:0]} >= geom_heads);
  wire        out_range = lba_mode ? (lba_cur > max_lba) : chs_bad;
  wire        sect_end  = sect_q == geom_spt;
  wire        head_end  = {1'b0, head_q[3:0]} == (geom_heads - 5'h01);
  wire [15:0] cyl_cur   = {cylhi_q, cyllo_q};
  wire [15:0] cyl_chs   = (sect_end && head_end) ? cyl_cur + 16'h0001 : cyl_cur;
  wire [3:0]  head_chs  = sect_end ? (head_end ? 4'h0 : head_q[3:0] + 4'h1) : head_q[3:0];
  wire [7:0]  sect_nx   = lba_mode ? lba_nx[7:0] : (sect_end ? 8'h01 : sect_q + 8'h01);
  wire [15:0] cyl_nx    = lba_mode ? lba_nx[23:8] : cyl_chs;
  wire [3:0]  head_nx   = lba_mode ? lba_nx[27:24] : head_chs;

  // check before each sector; media change events only on the first pass, no media on every pass
  wire chk_abort_flag = (is_vfy ? packet_set : (is_pw ? (!sec_supported || sec_locked || sec_frozen) : 1'b1))
                  || dev_fault;
  wire chk_nm   = is_vfy && removable && no_media;
  wire chk_mc   = is_vfy && first_q && removable && mc_pend_q;
  wire chk_mcr  = is_vfy && first_q && removable && mcr_pend_q;
  // out of range by itself never sets abort
  wire chk_nf   = is_vfy && ((!lba_mode && !chs_valid) || out_range);
  wire [7:0] chk_err = (8'(chk_abort_flag) << `DVP_ER_ABORT_FLAG) | (8'(chk_nm) << `DVP_ER_NM) | (8'(chk_mc) << `DVP_ER_MC)
                     | (8'(chk_mcr) << `DVP_ER_MCR) | (8'(chk_nf) << `DVP_ER_NF);
  wire [7:0] ack_err = (8'(media_unc) << `DVP_ER_UNC) | (8'(media_nf) << `DVP_ER_NF);
  wire       media_clr = in_chk && first_q && is_vfy;
  wire       adv       = in_wait && media_ack && (ack_err == 8'h00) && (remain_q != 9'h001);
  wire       issue     = in_chk && (state_d == dvp_pkg::S_WAIT);
  wire       to_data   = in_chk && (state_d == dvp_pkg::S_DATA);

  // status images
  wire       fin_fault = dev_fault && (fin_err != 8'h00);
  wire [7:0] busy_st   = 8'(1) << `DVP_ST_BUSY;
  wire [7:0] drq_st    = (8'(1) << `DVP_ST_DRIVE_READY_FLAG) | (8'(1) << `DVP_ST_DRQ);
  // done: busy and data request clear, ready set
  wire [7:0] fin_st    = (8'(1) << `DVP_ST_DRIVE_READY_FLAG) | (8'(fin_fault) << `DVP_ST_FAULT)
                       | (8'(fin_err != 8'h00) << `DVP_ST_ERR);

  // password selection
  wire [3:0]  pw_ix    = widx_q[3:0] - 4'h1;
  wire [15:0] ref_word = sel_master_q ? pw_mst[pw_ix] : pw_usr[pw_ix];
  wire        pw_ok    = fin && is_pw && (fin_err == 8'h00);

  // ********************************************************
  // sequencing
  // ********************************************************
  always_comb begin
    state_d = state_q;
    fin     = 1'b0;
    fin_err = 8'h00;
    case (state_q)
      dvp_pkg::S_IDLE: begin
        if (cmd_wr) begin
          state_d = dvp_pkg::S_CHECK;
        end
      end
      dvp_pkg::S_CHECK: begin
        if (chk_err != 8'h00) begin
          fin     = 1'b1;
          fin_err = chk_err;
        end else if (is_vfy) begin
          state_d = dvp_pkg::S_WAIT;
        end else begin
          state_d = dvp_pkg::S_DATA;
        end
      end
      dvp_pkg::S_WAIT: begin
        if (media_ack) begin
          if (ack_err != 8'h00) begin
            // address registers still hold the failing sector
            fin     = 1'b1;
            fin_err = ack_err;
          end else if (remain_q == 9'h001) begin
            fin = 1'b1;
          end else begin
            state_d = dvp_pkg::S_CHECK;
          end
        end
      end
      dvp_pkg::S_DATA: begin
        if (tf.pio_wr && (widx_q == `DVP_PW_LASTW)) begin
          fin     = 1'b1;
          fin_err = pw_match ? 8'h00 : (8'(1) << `DVP_ER_ABORT_FLAG);
        end
      end
      default: begin
        state_d = dvp_pkg::S_IDLE;
      end
    endcase
    if (fin) begin
      state_d = dvp_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= dvp_pkg::S_IDLE;
      status_q <= `DVP_STATUS_RST;
      error_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      if (fin) begin
        status_q <= fin_st;
        error_q  <= fin_err;
      end else if (cmd_wr) begin
        status_q <= busy_st;
      end else if (to_data) begin
        status_q <= drq_st;
      end
    end
  end

  // ********************************************************
  // task-file registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q    <= `DVP_TF_RST;
      cnt_q   <= `DVP_TF_RST;
      sect_q  <= `DVP_TF_RST;
      cyllo_q <= `DVP_TF_RST;
      cylhi_q <= `DVP_TF_RST;
      head_q  <= `DVP_TF_RST;
    end else begin
      if (cmd_wr) op_q <= tf.tf_wdata;
      if (tf_ld && (tf.tf_addr == `DVP_TF_CNT)) cnt_q <= tf.tf_wdata;
      if (tf_ld && (tf.tf_addr == `DVP_TF_SECT)) sect_q <= tf.tf_wdata;
      else if (adv) sect_q <= sect_nx;
      if (tf_ld && (tf.tf_addr == `DVP_TF_CYLLO)) cyllo_q <= tf.tf_wdata;
      else if (adv) cyllo_q <= cyl_nx[7:0];
      if (tf_ld && (tf.tf_addr == `DVP_TF_CYLHI)) cylhi_q <= tf.tf_wdata;
      else if (adv) cylhi_q <= cyl_nx[15:8];
      if (tf_ld && (tf.tf_addr == `DVP_TF_HEAD)) head_q <= tf.tf_wdata;
      else if (adv) head_q <= {head_q[7:4], head_nx};
    end
  end

  // ********************************************************
  // sector walk and media requests
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      remain_q   <= 9'h000;
      first_q    <= 1'b0;
      media_req  <= 1'b0;
      media_addr <= 28'h0000000;
      media_lba  <= 1'b0;
    end else begin
      if (cmd_wr) remain_q <= {cnt_q == 8'h00, cnt_q};
      else if (adv) remain_q <= remain_q - 9'h001;
      if (cmd_wr) first_q <= 1'b1;
      else if (in_chk) first_q <= 1'b0;
      if (issue) begin
        media_req  <= 1'b1;
        media_addr <= lba_cur;
        media_lba  <= lba_mode;
      end else if (media_ack) begin
        media_req <= 1'b0;
      end
    end
  end

  // pending media events: a new event outranks the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      mc_pend_q  <= 1'b0;
      mcr_pend_q <= 1'b0;
    end else begin
      mc_pend_q  <= media_change_evt || (mc_pend_q && !media_clr);
      mcr_pend_q <= media_change_req_evt || (mcr_pend_q && !media_clr);
    end
  end

  // ********************************************************
  // password data-out and lock state
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      widx_q       <= 9'h000;
      sel_master_q <= 1'b0;
      lock_mode    <= 1'b0;
    end else begin
      if (cmd_wr) widx_q <= 9'h000;
      else if (pw_take) widx_q <= widx_q + 9'h001;
      if (pw_take && (widx_q == 9'h000)) sel_master_q <= tf.pio_data[0];
      // leaving lock mode never touches the master password
      if (pw_ok) lock_mode <= 1'b0;
      if (pw_load && !pw_master) lock_mode <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (pw_load && pw_master) pw_mst[pw_idx] <= pw_word;
    if (pw_load && !pw_master) pw_usr[pw_idx] <= pw_word;
  end

  dvp_pw_cmp u_cmp (
    .clk      (clk),
    .rst      (rst),
    .start    (cmd_wr),
    .word_en  (pw_take),
    .idx      (widx_q),
    .word     (tf.pio_data),
    .ref_word (ref_word),
    .match    (pw_match)
  );

  assign tf.tf_status = status_q;
  assign tf.tf_error  = error_q;
  assign tf.tf_sect   = sect_q;
  assign tf.tf_cyl_lo = cyllo_q;
  assign tf.tf_cyl_hi = cylhi_q;
  assign tf.tf_head   = head_q;
endmodule
`default_nettype wire

// ===== rtl/dvp_regs.svh
// task-file indices, opcodes, bit positions, reset values and host register map
`ifndef DVP_REGS_SVH
`define DVP_REGS_SVH
// task-file register indices on the link
`define DVP_TF_FEAT   3'h1
`define DVP_TF_CNT    3'h2
`define DVP_TF_SECT   3'h3
`define DVP_TF_CYLLO  3'h4
`define DVP_TF_CYLHI  3'h5
`define DVP_TF_HEAD   3'h6
`define DVP_TF_CMD    3'h7
// command opcodes
`define DVP_OP_VERIFY 8'h40
`define DVP_OP_PWDIS  8'hf6
// completion_status bits
`define DVP_ST_BUSY   7
`define DVP_ST_DRIVE_READY_FLAG   6
`define DVP_ST_FAULT  5
`define DVP_ST_DRQ    3
`define DVP_ST_ERR    0
// error_flags bits
`define DVP_ER_UNC    6
`define DVP_ER_MC     5
`define DVP_ER_NF     4
`define DVP_ER_MCR    3
`define DVP_ER_ABORT_FLAG   2
`define DVP_ER_NM     1
// drive_and_head_select addressing-form bit
`define DVP_HD_LBA    6
// password sector layout, in 16-bit words
`define DVP_PW_LASTW  9'h0ff
`define DVP_PW_FIRST  9'h001
`define DVP_PW_LAST   9'h010
`define DVP_PW_BUF    17
// reset values
`define DVP_STATUS_RST 8'h40
`define DVP_TF_RST     8'h00
// host register offsets
`define DVP_HR_CMD    8'h00
`define DVP_HR_TF     8'h04
`define DVP_HR_HD     8'h08
`define DVP_HR_PW     8'h0c
`define DVP_HR_STAT   8'h10
`define DVP_HR_RES    8'h14
`define DVP_HR_BUSY   16
`define DVP_HR_REFUSE 17
`define DVP_RESP_OK   2'b00
`define DVP_RESP_ERR  2'b10
`endif

// ===== rtl/dvp_pkg.sv
// state types shared by both ends
package dvp_pkg;
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_WAIT, S_DATA} dvp_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_LOAD, H_WAIT} dvp_host_state_t;
endpackage

// ===== rtl/dvp_if.sv
// task-file link between the host adapter and the device
`timescale 1ns/10ps
`default_nettype none
interface dvp_if;
  logic       tf_wr;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic       pio_wr;
  logic [15:0] pio_data;
  logic [7:0] tf_status;
  logic [7:0] tf_error;
  logic [7:0] tf_sect;
  logic [7:0] tf_cyl_lo;
  logic [7:0] tf_cyl_hi;
  logic [7:0] tf_head;
  modport device (input tf_wr, tf_addr, tf_wdata, pio_wr, pio_data,
                  output tf_status, tf_error, tf_sect, tf_cyl_lo, tf_cyl_hi, tf_head);
  modport host (output tf_wr, tf_addr, tf_wdata, pio_wr, pio_data,
                input tf_status, tf_error, tf_sect, tf_cyl_lo, tf_cyl_hi, tf_head);
endinterface
`default_nettype wire

// ===== rtl/dvp_pw_cmp.sv
// password word comparator over one data-out sector
`timescale 1ns/10ps
`default_nettype none
`include "dvp_regs.svh"
module dvp_pw_cmp (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // word stream
  input  wire logic        start,
  input  wire logic        word_en,
  input  wire logic [8:0]  idx,
  input  wire logic [15:0] word,
  input  wire logic [15:0] ref_word,
  // result
  output logic             match
);
  wire in_pw = (idx >= `DVP_PW_FIRST) && (idx <= `DVP_PW_LAST);
  wire miss  = word_en && in_pw && (word != ref_word);

  always_ff @(posedge clk) begin
    if (rst || start) begin
      match <= 1'b1;
    end else if (miss) begin
      match <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dvp_host.sv
// host adapter end: AXI4-Lite registers driving the task-file link
`timescale 1ns/10ps
`default_nettype none
`include "dvp_regs.svh"
module dvp_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // task-file link
  dvp_if.host              tf,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  dvp_pkg::dvp_host_state_t state_q;
  logic [31:0] tfa_q;
  logic [15:0] tfb_q;
  logic [7:0]  op_q;
  logic [2:0]  ld_q;
  logic [8:0]  pcnt_q;
  logic        refused_q;
  logic [15:0] pw_buf [`DVP_PW_BUF];

  // ********************************************************
  // register decode
  // ********************************************************
  wire        wr_hs   = awready && awvalid && wready && wvalid;
  wire        rd_hs   = arready && arvalid;
  wire [31:0] wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] tfa_new = (tfa_q & ~wmask) | (wdata & wmask);
  wire [31:0] tfb_new = ({16'h0000, tfb_q} & ~wmask) | (wdata & wmask);
  wire        w_ok    = (awaddr <= `DVP_HR_PW) && (awaddr[1:0] == 2'b00);
  wire        r_ok    = (araddr <= `DVP_HR_RES) && (araddr[1:0] == 2'b00);
  wire        idle    = state_q == dvp_pkg::H_IDLE;
  wire        go      = wr_hs && (awaddr == `DVP_HR_CMD) && wstrb[0] && idle;
  wire        drive_ready_flag    = tf.tf_status[`DVP_ST_DRIVE_READY_FLAG];
  wire        dbusy   = tf.tf_status[`DVP_ST_BUSY];
  wire        data_request_flag     = tf.tf_status[`DVP_ST_DRQ];
  // password disable only against a ready, idle device
  wire        refuse  = (wdata[7:0] == `DVP_OP_PWDIS) && (!drive_ready_flag || dbusy);
  wire        send    = (state_q == dvp_pkg::H_WAIT) && data_request_flag && (op_q == `DVP_OP_PWDIS) && !pcnt_q[8];
  // the command write is still in flight for one cycle; busy only shows after it lands
  wire        done    = (state_q == dvp_pkg::H_WAIT) && !tf.tf_wr && !dbusy && !data_request_flag && !tf.pio_wr;
  wire [31:0] stat    = {14'h0000, refused_q, !idle, tf.tf_error, tf.tf_status};
  wire [31:0] res     = {tf.tf_head, tf.tf_cyl_hi, tf.tf_cyl_lo, tf.tf_sect};
  wire [31:0] rd_mux  = (araddr == `DVP_HR_TF) ? tfa_q : (araddr == `DVP_HR_HD) ? {16'h0000, tfb_q} :
                        (araddr == `DVP_HR_STAT) ? stat : (araddr == `DVP_HR_RES) ? res : 32'h00000000;
  wire [7:0]  ld_data = (ld_q == `DVP_TF_FEAT) ? tfb_q[15:8] : (ld_q == `DVP_TF_CNT) ? tfa_q[7:0] :
                        (ld_q == `DVP_TF_SECT) ? tfa_q[15:8] : (ld_q == `DVP_TF_CYLLO) ? tfa_q[23:16] :
                        (ld_q == `DVP_TF_CYLHI) ? tfa_q[31:24] : (ld_q == `DVP_TF_HEAD) ? tfb_q[7:0] : op_q;
  wire [15:0] pw_out  = (pcnt_q < 9'(`DVP_PW_BUF)) ? pw_buf[pcnt_q[4:0]] : 16'h0000;

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `DVP_RESP_OK;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= `DVP_RESP_OK;
      rdata   <= 32'h00000000;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
      if (wr_hs) begin
        bvalid <= 1'b1;
        bresp  <= w_ok ? `DVP_RESP_OK : `DVP_RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (rd_hs) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= r_ok ? `DVP_RESP_OK : `DVP_RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tfa_q <= 32'h00000000;
      tfb_q <= 16'h0000;
    end else if (wr_hs && idle) begin
      if (awaddr == `DVP_HR_TF) tfa_q <= tfa_new;
      if (awaddr == `DVP_HR_HD) tfb_q <= tfb_new[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_hs && (awaddr == `DVP_HR_PW) && (wdata[20:16] < 5'(`DVP_PW_BUF))) pw_buf[wdata[20:16]] <= wdata[15:0];
  end

  // ********************************************************
  // command sequencer
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= dvp_pkg::H_IDLE;
      op_q        <= 8'h00;
      ld_q        <= `DVP_TF_FEAT;
      pcnt_q      <= 9'h000;
      refused_q   <= 1'b0;
      tf.tf_wr    <= 1'b0;
      tf.tf_addr  <= 3'h0;
      tf.tf_wdata <= 8'h00;
      tf.pio_wr   <= 1'b0;
      tf.pio_data <= 16'h0000;
    end else begin
      tf.tf_wr  <= 1'b0;
      tf.pio_wr <= send;
      if (send) begin
        tf.pio_data <= pw_out;
        pcnt_q      <= pcnt_q + 9'h001;
      end
      case (state_q)
        dvp_pkg::H_IDLE: begin
          if (go) begin
            refused_q <= refuse;
            op_q      <= wdata[7:0];
            ld_q      <= `DVP_TF_FEAT;
            pcnt_q    <= 9'h000;
            if (!refuse) state_q <= dvp_pkg::H_LOAD;
          end
        end
        dvp_pkg::H_LOAD: begin
          tf.tf_wr    <= 1'b1;
          tf.tf_addr  <= ld_q;
          tf.tf_wdata <= ld_data;
          ld_q        <= ld_q + 3'h1;
          if (ld_q == `DVP_TF_CMD) state_q <= dvp_pkg::H_WAIT;
        end
        dvp_pkg::H_WAIT: begin
          if (done) state_q <= dvp_pkg::H_IDLE;
        end
        default: begin
          state_q <= dvp_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verification/dvp_properties.sv
// concurrent checks on the task-file link between the two ends
`timescale 1ns/10ps
`default_nettype none
module dvp_checker (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // task-file link
  input  wire logic       tf_wr,
  input  wire logic [2:0] tf_addr,
  input  wire logic [7:0] tf_wdata,
  input  wire logic [7:0] tf_status,
  input  wire logic [7:0] tf_error
);
  // ****************
  // properties
  // ****************
  // idle also excludes the data-out phase, where busy is low but a command runs
  wire idle = !tf_status[7] && !tf_status[3];
  wire go   = tf_wr && tf_addr == 3'h7 && idle;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_START: assert property (go |=> tf_status == 8'h80) else $error("busy not raised");
  AST_NO_DRQ: assert property (go && tf_wdata == 8'h40 |=> !tf_status[3] [*8]) else $error("verify requested data");
  AST_OK: assert property (!$past(idle) && idle && !tf_status[0] |-> tf_status == 8'h40 && tf_error == 8'h00)
    else $error("bad success status");
  AST_ERR: assert property (!$past(idle) && idle |-> tf_status[6] && tf_status[0] == |tf_error)
    else $error("error flag disagrees with error bits");
  AST_FAULT: assert property (tf_status[5] |-> tf_error[2]) else $error("fault without abort");
  AST_EXCL: assert property (!(tf_error[4] && tf_error[2])) else $error("range flagged twice");
  AST_BAD_OP: assert property (go && tf_wdata != 8'h40 && tf_wdata != 8'hf6 |-> ##[2:4] (tf_status & 8'hdf) == 8'h41
    && tf_error[2]) else $error("unknown opcode not aborted");
  AST_HOLD: assert property (idle && !go |=> $stable(tf_status) && $stable(tf_error))
    else $error("status moved while idle");
endmodule
`default_nettype wire

// ===== verification/disk_verify_and_password_disable_cmd_bench.sv
// self-checking bench: host and device ends joined over the task-file link
`timescale 1ns/10ps
`default_nettype none
`include "dvp_regs.svh"
module disk_verify_and_password_disable_cmd_bench;
  logic        clk = 1'h0, rst = 1'h1, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, packet_set, removable, sec_supported, sec_locked, sec_frozen, dev_fault;
  logic        no_media, media_change_evt, media_change_req_evt, pw_load, pw_master, fail_nf;
  logic        media_ack = 1'h0, media_unc = 1'h0, media_nf = 1'h0, media_req, media_lba, lock_mode, first_lba;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  pw_idx;
  logic [7:0]  awaddr, araddr, em [9];
  logic [15:0] pw_word, pwb;
  logic [27:0] media_addr, first_addr, a;
  logic [31:0] wdata, rdata, st, r;
  int          error_cnt = 0, checks = 0, secs = 0, fail_at = 0, n;
  always #4 clk = ~clk;
  dvp_if tfi ();
  dvp_device dvp_device_inst (.clk, .rst, .tf(tfi.device), .packet_set, .removable, .sec_supported, .sec_locked,
    .sec_frozen, .chs_valid(1'h1), .dev_fault, .max_lba(28'h7ffffff), .geom_spt(8'h3f), .geom_heads(5'h10),
    .media_change_evt, .media_change_req_evt, .no_media, .media_req, .media_addr, .media_lba, .media_ack,
    .media_unc, .media_nf, .pw_load, .pw_master, .pw_idx, .pw_word, .lock_mode);
  dvp_host dvp_host_inst (.clk, .rst, .tf(tfi.host), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  dvp_checker dvp_checker_inst (.clk, .rst, .tf_wr(tfi.tf_wr), .tf_addr(tfi.tf_addr), .tf_wdata(tfi.tf_wdata),
    .tf_status(tfi.tf_status), .tf_error(tfi.tf_error));
  // media answers at random pace; sector number fail_at fails, none when fail_at is zero
  always @(posedge clk) begin
    media_ack <= 1'h0;
    if (media_req && !media_ack && $urandom_range(0, 1)) begin
      if (secs == 0) first_addr <= media_addr;
      if (secs == 0) first_lba <= media_lba;
      secs++;
      media_ack <= 1'h1;
      media_unc <= secs == fail_at && !fail_nf;
      media_nf <= secs == fail_at && fail_nf;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int exp_secs(input int cnt, input int fail);
    return fail ? fail : (cnt ? cnt : 256);
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'h7};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    {araddr, arvalid, rready} <= {ad, 2'h3};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  // polls until both host and device are done; only the watchdog ends a hang
  task automatic run(input logic [7:0] op);
    secs = 0;
    wr(`DVP_HR_CMD, {24'h0, op});
    do begin
      rd(`DVP_HR_STAT, st);
    end while (st[16] || st[7]);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    print_verdict;
  end
  // ****************
  // tests
  // ****************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, packet_set, removable, sec_locked, sec_frozen, dev_fault, no_media,
     media_change_evt, media_change_req_evt, pw_load, pw_master, fail_nf, awaddr, araddr, wdata, pw_idx, pw_word} <= '0;
    sec_supported <= 1'h1;
    em = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h02, 8'h20, 8'h08, 8'h04, 8'h04};
    void'($urandom(32'h08a6));
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd(`DVP_HR_STAT, st);
    chk(st[15:0], {`DVP_TF_RST, `DVP_STATUS_RST});
    rd(8'h3c, r);
    chk(rs, `DVP_RESP_ERR);
    for (int k = 0; k < 5; k++) begin
      a = (k == 3) ? {12'h0, 8'($urandom), 8'h01} : 28'($urandom) & 28'h3ffffff;
      n = (k == 1) ? 0 : (k == 2) ? 4 : $urandom_range(1, 4);
      fail_at = (k == 2) ? 3 : int'(k == 4);
      fail_nf = k == 4;
      wr(`DVP_HR_TF, {a[23:0], 8'(n)});
      wr(`DVP_HR_HD, {24'h0, 1'h0, k != 3, 2'h0, a[27:24]});
      run(`DVP_OP_VERIFY);
      chk(secs, exp_secs(n, fail_at));
      chk(st[15:0], k == 2 ? 16'h4041 : k == 4 ? 16'h1041 : 16'h0040);
      chk(first_lba, k != 3);
      if (k != 3) chk(first_addr, a);
      rd(`DVP_HR_RES, r);
      if (fail_at) chk(r[27:0], a + fail_at - 1);
      $display("verify test %0d done", k);
    end
    fail_at = 0;
    for (int e = 0; e < 9; e++) begin
      {removable, packet_set, sec_frozen, sec_locked, no_media, dev_fault} <= {1'h1, e == 1, e == 2, e == 3, e == 4, e == 7};
      sec_supported <= e != 8;
      @(posedge clk) {media_change_evt, media_change_req_evt} <= {e == 5, e == 6};
      @(posedge clk) {media_change_evt, media_change_req_evt} <= 2'h0;
      run(e == 0 ? 8'h20 : (e == 2 || e == 3 || e == 8) ? `DVP_OP_PWDIS : `DVP_OP_VERIFY);
      chk(st[15:8] & em[e], em[e]);
      chk(st[7:0] & 8'he9, e == 7 ? 8'h61 : 8'h41);
      if (e == 6) chk(st[13], 1'h0);
      $display("error test %0d done", e);
    end
    {removable, dev_fault, sec_supported} <= 3'h1;
    pwb = 16'($urandom);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {pw_load, pw_master, pw_idx, pw_word} <= {1'h1, i[4], i[3:0], (pwb ^ {16{i[4]}}) + 16'(i[3:0])};
    end
    @(posedge clk) pw_load <= 1'h0;
    @(posedge clk);
    chk(lock_mode, 1'h1);
    for (int t = 0; t < 3; t++) begin
      wr(`DVP_HR_PW, {31'h0, t == 1});
      for (int i = 1; i < 17; i++) wr(`DVP_HR_PW, {11'h0, 5'(i), pwb + 16'(i - 1) + (t == 0)});
      run(`DVP_OP_PWDIS);
      chk(st[15:0], t == 2 ? 16'h0040 : 16'h0441);
      chk(lock_mode, t != 2);
      $display("password test %0d done", t);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
